// file: shared/timer_map.svh
// offsets, field positions, reset values and clock select codes of the capture/compare timer
// assumes a 32-bit AHB-Lite slave, one register per aligned word
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// word indices (byte address = 4 * index)
`define IDX_CTL_ONE   4'h0
`define IDX_CTL_TWO   4'h1
`define IDX_STATUS    4'h2
`define IDX_CAP_A     4'h3
`define IDX_CMP_A     4'h4
`define IDX_CMP_B     4'h5
`define IDX_COUNT     4'h6
`define IDX_ALT_COUNT 4'h7
`define IDX_CAP_B     4'h8

// control one fields
`define C1_CAP_IE     7
`define C1_CMP_IE     6
`define C1_OVF_IE     5
`define C1_FORCE_B    4
`define C1_FORCE_A    3
`define C1_LEVEL_B    2
`define C1_CAP_A_EDGE 1
`define C1_LEVEL_A    0

// control two fields
`define C2_PIN_A_EN   7
`define C2_PIN_B_EN   6
`define C2_PULSE      5
`define C2_PWM        4
`define C2_CLK_HI     3
`define C2_CLK_LO     2
`define C2_CAP_B_EDGE 1
`define C2_EXT_EDGE   0

// status fields
`define ST_CAP_A      7
`define ST_CMP_A      6
`define ST_OVF        5
`define ST_CAP_B      4
`define ST_CMP_B      3

// reset and load values
`define CTL_RST       8'h00
`define CNT_RST       16'hfffc
`define CNT_ALL_ONES  16'hffff
`define CAP_PULSE     16'hfffd
`define CMP_RST       16'h8000

// clock select codes
`define CLK_DIV4      2'b00
`define CLK_DIV2      2'b01
`define CLK_DIV8      2'b10
`define CLK_EXT       2'b11

`endif

// file: shared/timer_pkg.sv
// types of the capture/compare timer: bus request carrier and the module state
// assumes timer_map.svh supplies all numbers
package timer_pkg;

	typedef struct packed {
		logic        hsel;
		logic [1:0]  htrans;
		logic [31:0] haddr;
		logic        hwrite;
		logic [2:0]  hsize;
	} ahb_req_t;

	typedef struct packed {
		logic [7:0]  ctl_one;
		logic [7:0]  ctl_two;
		logic [15:0] count;
		logic [15:0] cap_a;
		logic [15:0] cap_b;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [2:0]  div;
		logic        cap_a_flag;
		logic        cap_b_flag;
		logic        cmp_a_flag;
		logic        cmp_b_flag;
		logic        ovf_flag;
		logic [7:0]  clr_arm;
		logic [2:0]  sy_a;
		logic [2:0]  sy_b;
		logic [2:0]  sy_x;
		logic [2:0]  flt;
		logic        arm_a;
		logic        arm_b;
		logic        stop_q;
		logic        out_a;
		logic        out_b;
		logic        wr_pend;
		logic [3:0]  wr_idx;
		logic [31:0] rdata;
	} state_t;

endpackage

// file: hdl/capture_compare_timer.sv
// 16-bit free-running timer: control, capture, compare, pulse/PWM, low-power behaviour
// assumes one AHB-Lite master, pins asynchronous to hclk, stop/idle levels from the power manager
//
// Function
// [R1] idle sleep: timer runs on; an enabled timer interrupt wakes the device.
// [R2] deep stop: registers and counter freeze; interrupt wake resumes, reset restarts.
// [R3] capture edge during stop arms; interrupt wake sets flag, captures exit count.
// [R4] all events share one interrupt, gated by own enable and global mask.
// [R5] capture A flag from input A or PWM reset; no event wakes stop.
// [R6] PWM mode never raises either compare flag.
// [R7] capture enable requests interrupt while either capture flag is set.
// [R8] compare enable requests interrupt while either compare flag is set.
// [R9] overflow enable requests interrupt while overflow flag is set.
// [R10] force_level_b copies level_b to output B without a match.
// [R11] force_level_a copies level_a to output A without a match.
// [R12] level_b goes to output B on match B; to output A in pulse/PWM.
// [R13] capture_a_edge_sel: 0 falling, 1 rising edge on input A.
// [R14] level_a goes to output A on every match against compare_a_value.
// [R15] compare_a_pin_enable only routes the timer signal to pin A.
// [R16] compare_b_pin_enable only routes level_b to pin B.
// [R17] single pulse: selected edge on input A starts one pulse on output A.
// [R18] PWM: output A repeats; compare A sets pulse, compare B period.
// [R19] clock_select: 00 /4, 01 /2, 10 /8, 11 external clock.
// [R20] external clock selected but absent halts the counter.
// [R21] three control/status registers and six 16-bit data registers.
// [R22] flag clear: read status while set, then access event's data register.
// [R23] capture_b_edge_sel: 0 falling, 1 rising edge on input B.
// [R24] ext_clock_edge_sel: 0 falling, 1 rising edge advances the counter.
// [R25] PWM: compare B match reloads counter to fffc.
// [R26] 16-bit up-counter, one step per tick, overflow flag on wrap.
// [R27] control registers read back and reset to zero.
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "timer_map.svh"

module capture_compare_timer
	import timer_pkg::*;
#(
	parameter bit HAS_EXT_CLK = 1'b1
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire ahb_req_t    ahb_req,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        capture_a_in,
	input  wire logic        capture_b_in,
	input  wire logic        ext_count_clock,
	output logic             compare_a_out,
	output logic             compare_a_oe,
	output logic             compare_b_out,
	output logic             compare_b_oe,
	input  wire logic        irq_mask,
	input  wire logic        idle_mode,
	input  wire logic        stop_mode,
	output logic             timer_irq,
	output logic             wake_idle
);

	state_t q;
	state_t d;

	logic       running;
	logic       tick;
	logic       pwm;
	logic       pulse;
	logic       edge_a;
	logic       edge_b;
	logic       edge_x;
	logic       stop_exit;
	logic       bus_take;
	logic       cnt_wr;
	logic [3:0] idx;
	logic       idx_ok;
	logic       sel_eight;

	// a change counts only once the last two stages agree and differ from the held level
	function automatic logic edge_hit(input logic [1:0] s, input logic held, input logic sel);
		edge_hit = (s[0] == s[1]) && (s[1] != held) && (s[1] == sel);
	endfunction

	function automatic logic tick_fn(input logic [1:0] sel, input logic [2:0] div,
		input logic ext_edge, input logic has_ext);
		case (sel)
			`CLK_DIV4: tick_fn = (div[1:0] == 2'b11);
			`CLK_DIV2: tick_fn = div[0];
			`CLK_DIV8: tick_fn = (div == 3'b111);
			default:   tick_fn = has_ext && ext_edge;
		endcase
	endfunction

	function automatic logic [31:0] read_fn(input logic [3:0] i, input state_t s); // R21
		case (i)
			`IDX_CTL_ONE:   read_fn = {24'h000000, s.ctl_one};
			`IDX_CTL_TWO:   read_fn = {24'h000000, s.ctl_two};
			`IDX_STATUS:    read_fn = {24'h000000, s.cap_a_flag, s.cmp_a_flag, s.ovf_flag,
				s.cap_b_flag, s.cmp_b_flag, 3'b000};
			`IDX_CAP_A:     read_fn = {16'h0000, s.cap_a};
			`IDX_CMP_A:     read_fn = {16'h0000, s.cmp_a};
			`IDX_CMP_B:     read_fn = {16'h0000, s.cmp_b};
			`IDX_COUNT:     read_fn = {16'h0000, s.count};
			`IDX_ALT_COUNT: read_fn = {16'h0000, s.count};
			`IDX_CAP_B:     read_fn = {16'h0000, s.cap_b};
			default:        read_fn = 32'h00000000;
		endcase
	endfunction

	assign pwm       = q.ctl_two[`C2_PWM];
	assign pulse     = q.ctl_two[`C2_PULSE] && !pwm;
	assign running   = !stop_mode;
	assign stop_exit = q.stop_q && !stop_mode;
	assign edge_a    = edge_hit(q.sy_a[2:1], q.flt[0], q.ctl_one[`C1_CAP_A_EDGE]); // R13
	assign edge_b    = edge_hit(q.sy_b[2:1], q.flt[1], q.ctl_two[`C2_CAP_B_EDGE]); // R23
	assign edge_x    = edge_hit(q.sy_x[2:1], q.flt[2], q.ctl_two[`C2_EXT_EDGE]);   // R24
	assign tick      = running && tick_fn(q.ctl_two[`C2_CLK_HI:`C2_CLK_LO], q.div,
		edge_x, HAS_EXT_CLK); // R19 R20
	assign bus_take  = ahb_req.hsel && ahb_req.htrans[1] && hready;
	assign idx       = ahb_req.haddr[5:2];
	assign idx_ok    = (ahb_req.haddr[31:6] == 26'h0000000);
	assign cnt_wr    = q.wr_pend && running &&
		(q.wr_idx == `IDX_COUNT || q.wr_idx == `IDX_ALT_COUNT);
	assign sel_eight = (q.ctl_two[`C2_CLK_HI:`C2_CLK_LO] == `CLK_DIV8);

	always_comb begin
		d = q;
		d.stop_q = stop_mode;
		d.sy_a = {q.sy_a[1:0], capture_a_in};
		d.sy_b = {q.sy_b[1:0], capture_b_in};
		d.sy_x = {q.sy_x[1:0], ext_count_clock};
		if (q.sy_a[1] == q.sy_a[2]) begin
			d.flt[0] = q.sy_a[2];
		end
		if (q.sy_b[1] == q.sy_b[2]) begin
			d.flt[1] = q.sy_b[2];
		end
		if (q.sy_x[1] == q.sy_x[2]) begin
			d.flt[2] = q.sy_x[2];
		end

		// address phase: reads answer next cycle, flag clears come first so sets win
		d.wr_pend = 1'b0;
		if (bus_take) begin
			d.rdata = idx_ok ? read_fn(idx, q) : 32'h00000000;
			d.wr_pend = ahb_req.hwrite && idx_ok;
			d.wr_idx = idx;
			if (idx_ok && idx == `IDX_STATUS && !ahb_req.hwrite) begin
				d.clr_arm = {3'b000, q.cap_a_flag, q.cmp_a_flag, q.ovf_flag,
					q.cap_b_flag, q.cmp_b_flag}; // R22
			end
			if (idx_ok) begin
				case (idx)
					`IDX_CAP_A: begin
						if (q.clr_arm[4]) begin
							d.cap_a_flag = 1'b0; // R22
						end
						d.clr_arm[4] = 1'b0;
					end
					`IDX_CMP_A: begin
						if (q.clr_arm[3]) begin
							d.cmp_a_flag = 1'b0; // R22
						end
						d.clr_arm[3] = 1'b0;
					end
					`IDX_COUNT: begin
						if (q.clr_arm[2]) begin
							d.ovf_flag = 1'b0; // R22
						end
						d.clr_arm[2] = 1'b0;
					end
					`IDX_CAP_B: begin
						if (q.clr_arm[1]) begin
							d.cap_b_flag = 1'b0; // R22
						end
						d.clr_arm[1] = 1'b0;
					end
					`IDX_CMP_B: begin
						if (q.clr_arm[0]) begin
							d.cmp_b_flag = 1'b0; // R22
						end
						d.clr_arm[0] = 1'b0;
					end
					default: begin
					end
				endcase
			end
		end

		// while stopped nothing moves; a capture edge only arms the input
		if (!running) begin
			if (edge_a && !pwm) begin
				d.arm_a = 1'b1; // R3
			end
			if (edge_b) begin
				d.arm_b = 1'b1; // R3
			end
		end else begin
			d.div = q.div + 3'd1;
			if (tick) begin
				if (pwm && q.count == q.cmp_b) begin
					d.count = `CNT_RST;                            // R25
					d.cap_a_flag = 1'b1;                           // R5
					d.out_a = q.ctl_one[`C1_LEVEL_B];              // R18
				end else begin
					d.count = q.count + 16'h0001;                  // R26
					if (q.count == `CNT_ALL_ONES) begin
						d.ovf_flag = 1'b1;                         // R26
					end
					if (q.count == q.cmp_a) begin
						d.out_a = q.ctl_one[`C1_LEVEL_A];          // R14 R17 R18
						if (!pwm && !pulse) begin
							d.cmp_a_flag = 1'b1;                   // R6
						end
					end
					if (q.count == q.cmp_b && !pwm) begin
						d.cmp_b_flag = 1'b1;                       // R6
						if (!pulse) begin
							d.out_b = q.ctl_one[`C1_LEVEL_B];      // R12
						end
					end
				end
			end
			if (edge_a && pulse) begin
				d.count = `CNT_RST;                                // R17
				d.out_a = q.ctl_one[`C1_LEVEL_B];                  // R12
				d.cap_a_flag = 1'b1;                               // R5
				d.cap_a = `CAP_PULSE;
			end else if (edge_a && !pwm) begin
				d.cap_a_flag = 1'b1;                               // R5
				d.cap_a = q.count;
			end
			if (edge_b) begin
				d.cap_b_flag = 1'b1;
				d.cap_b = q.count;
			end
			if (stop_exit) begin
				if (q.arm_a) begin
					d.cap_a_flag = 1'b1;                           // R3
					d.cap_a = q.count;
				end
				if (q.arm_b) begin
					d.cap_b_flag = 1'b1;                           // R3
					d.cap_b = q.count;
				end
				d.arm_a = 1'b0;
				d.arm_b = 1'b0;
			end
			// forcing is ignored in pulse and PWM modes, where output A is sequenced
			if (!pulse && !pwm) begin
				if (q.ctl_one[`C1_FORCE_A]) begin
					d.out_a = q.ctl_one[`C1_LEVEL_A];              // R11
				end
				if (q.ctl_one[`C1_FORCE_B]) begin
					d.out_b = q.ctl_one[`C1_LEVEL_B];              // R10
				end
			end
		end

		// data phase write; a counter write restarts the count unless stopped
		if (q.wr_pend) begin
			case (q.wr_idx)
				`IDX_CTL_ONE: d.ctl_one = hwdata[7:0];              // R27
				`IDX_CTL_TWO: d.ctl_two = hwdata[7:0];              // R27
				`IDX_CMP_A:   d.cmp_a = hwdata[15:0];
				`IDX_CMP_B:   d.cmp_b = hwdata[15:0];
				default: begin
				end
			endcase
			if (cnt_wr) begin
				d.count = `CNT_RST;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q         <= '0;
			q.count   <= `CNT_RST;                                  // R2
			q.cmp_a   <= `CMP_RST;
			q.cmp_b   <= `CMP_RST;
			q.ctl_one <= `CTL_RST;                                  // R27
			q.ctl_two <= `CTL_RST;
			q.sy_a    <= 3'b111;
			q.sy_b    <= 3'b111;
			q.sy_x    <= 3'b111;
			q.flt     <= 3'b111;
		end else begin
			q <= d;
		end
	end

	// one shared request, never a wake source from stop
	assign timer_irq = !irq_mask && (                                             // R4
		(q.ctl_one[`C1_CAP_IE] && (q.cap_a_flag || q.cap_b_flag)) ||            // R7
		(q.ctl_one[`C1_CMP_IE] && (q.cmp_a_flag || q.cmp_b_flag)) ||            // R8
		(q.ctl_one[`C1_OVF_IE] && q.ovf_flag));                                 // R9
	assign wake_idle = idle_mode && timer_irq;                                  // R1 R5

	assign compare_a_out = q.out_a;
	assign compare_a_oe  = q.ctl_two[`C2_PIN_A_EN];                             // R15
	assign compare_b_out = q.out_b;
	assign compare_b_oe  = q.ctl_two[`C2_PIN_B_EN];                             // R16
	assign hrdata    = q.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// one shared request: each enable gates its own flags, the global mask gates all
	irq_mask_gate_a: assert property (irq_mask |-> !timer_irq) // R4
		else $error("interrupt raised while globally masked");
	no_enable_irq_a: assert property (!q.ctl_one[`C1_CAP_IE] && // R4
		!q.ctl_one[`C1_CMP_IE] && !q.ctl_one[`C1_OVF_IE] |-> !timer_irq)
		else $error("interrupt without any enable");
	capture_irq_a: assert property (q.ctl_one[`C1_CAP_IE] && !irq_mask && // R7
		(q.cap_a_flag || q.cap_b_flag) |-> timer_irq)
		else $error("capture flag did not request interrupt");
	compare_irq_a: assert property (q.ctl_one[`C1_CMP_IE] && !irq_mask && // R8
		(q.cmp_a_flag || q.cmp_b_flag) |-> timer_irq)
		else $error("compare flag did not request interrupt");
	overflow_irq_a: assert property (q.ctl_one[`C1_OVF_IE] && !irq_mask && // R9
		q.ovf_flag |-> timer_irq)
		else $error("overflow flag did not request interrupt");

	// prescaler and counter
	stop_freeze_a: assert property (stop_mode // R2
		|=> $stable(q.count) && $stable(q.div))
		else $error("counter moved during stop");
	count_step_a: assert property (tick && !pwm && !cnt_wr && !(edge_a && pulse) // R26
		|=> q.count == $past(q.count) + 16'h0001)
		else $error("counter did not advance by one");
	count_wrap_a: assert property (tick && q.count == `CNT_ALL_ONES && !pwm && !cnt_wr // R26
		&& !(edge_a && pulse) |=> q.ovf_flag && q.count == 16'h0000)
		else $error("wrap did not set overflow");
	// seven quiet cycles between ticks; a change of source or a stop voids the window
	div_eight_a: assert property ((tick && sel_eight) ##1 // R19
		(!tick && running && sel_eight)[*7] ##1 (running && sel_eight) |-> tick)
		else $error("divide by eight spacing wrong");
	ext_absent_a: assert property (!HAS_EXT_CLK && // R20
		q.ctl_two[`C2_CLK_HI:`C2_CLK_LO] == `CLK_EXT |-> !tick)
		else $error("counter ticks with no external clock");

	// capture: edges seen in stop are only held until the interrupt wake
	stop_arm_a: assert property (stop_mode && edge_b |=> q.arm_b) // R3
		else $error("capture edge in stop not armed");
	wake_capture_a: assert property (stop_exit && q.arm_b // R3
		|=> q.cap_b_flag && q.cap_b == $past(q.count))
		else $error("armed capture not taken on wake");
	capture_b_a: assert property (running && edge_b // R23
		|=> q.cap_b_flag && q.cap_b == $past(q.count))
		else $error("capture b edge not stored");

	// compare outputs and the sequenced modes
	match_a_out_a: assert property (tick && q.count == q.cmp_a && !pwm && !pulse && // R14
		!q.ctl_one[`C1_FORCE_A] |=> q.out_a == $past(q.ctl_one[`C1_LEVEL_A]))
		else $error("match a did not drive level a");
	match_b_out_a: assert property (tick && q.count == q.cmp_b && !pwm && !pulse && // R12
		!q.ctl_one[`C1_FORCE_B]
		|=> q.out_b == $past(q.ctl_one[`C1_LEVEL_B]) && q.cmp_b_flag)
		else $error("match b did not drive level b");
	force_level_a: assert property (running && q.ctl_one[`C1_FORCE_A] && !pwm && !pulse // R11
		|=> q.out_a == $past(q.ctl_one[`C1_LEVEL_A]))
		else $error("forced level not on output a");
	force_b_a: assert property (running && q.ctl_one[`C1_FORCE_B] && !pwm && !pulse // R10
		|=> q.out_b == $past(q.ctl_one[`C1_LEVEL_B]))
		else $error("forced level not on output b");
	pwm_no_compare_a: assert property (pwm && !q.cmp_a_flag && !q.cmp_b_flag // R6
		|=> !q.cmp_a_flag && !q.cmp_b_flag)
		else $error("compare flag set in pwm mode");
	pwm_reload_a: assert property (tick && pwm && q.count == q.cmp_b && !cnt_wr // R25
		|=> q.count == `CNT_RST && q.cap_a_flag &&
		q.out_a == $past(q.ctl_one[`C1_LEVEL_B]))
		else $error("pwm period end did not reload");
	pulse_start_a: assert property (running && edge_a && pulse // R17
		|=> q.count == `CNT_RST && q.cap_a == `CAP_PULSE && q.cap_a_flag &&
		q.out_a == $past(q.ctl_one[`C1_LEVEL_B]))
		else $error("pulse trigger did not start the pulse");

endmodule // capture_compare_timer

`default_nettype wire

// file: tb/pin_far_side.sv
// far-side pin model: capture sources and the external count clock
// assumes the bench calls drive() right after a rising hclk edge
`timescale 1ns/100ps
`default_nettype none

module pin_far_side (
	input  wire logic hclk,
	output logic      capture_a_in,
	output logic      capture_b_in,
	output logic      ext_count_clock
);
	// capture pins idle high so the reset-high synchronisers see no false edge; the count clock starts low
	initial begin
		capture_a_in = 1'b1;
		capture_b_in = 1'b1;
		ext_count_clock = 1'b0;
	end

	// levels change once per call, one cycle after the caller's edge
	task automatic drive(input logic a, input logic b, input logic x);
		@(posedge hclk);
		capture_a_in <= a;
		capture_b_in <= b;
		ext_count_clock <= x;
	endtask
endmodule // pin_far_side

`default_nettype wire

// file: tb/capture_compare_timer_tb.sv
// self-checking bench of the capture/compare timer, registers over AHB-Lite
// assumes a zero-wait single slave (hready fed from hreadyout) and pin_far_side
`timescale 1ns/100ps
`default_nettype none
`include "timer_map.svh"
`define CHECK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin err_count++; \
$display("Error %s expected %h seen %h", nm, ex, ac); end end

module capture_compare_timer_tb
	import timer_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	ahb_req_t    ahb_req = '0;
	logic [31:0] hwdata = 32'h0;
	logic        irq_mask = 1'b0;
	logic        idle_mode = 1'b0;
	logic        stop_mode = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        cap_a;
	logic        cap_b;
	logic        ext_clk;
	logic        out_a;
	logic        oe_a;
	logic        out_b;
	logic        oe_b;
	logic        timer_irq;
	logic        wake_idle;
	logic [31:0] rd;
	logic [31:0] c0;
	logic [31:0] c1;
	logic [15:0] pw;
	logic [15:0] per;
	int          hi;
	int          err_count = 0;
	int          checked = 0;

	always #2 hclk = ~hclk;

	capture_compare_timer u_capture_compare_timer (.hclk(hclk), .hresetn(hresetn),
		.ahb_req(ahb_req), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .capture_a_in(cap_a), .capture_b_in(cap_b),
		.ext_count_clock(ext_clk), .compare_a_out(out_a), .compare_a_oe(oe_a),
		.compare_b_out(out_b), .compare_b_oe(oe_b), .irq_mask(irq_mask),
		.idle_mode(idle_mode), .stop_mode(stop_mode), .timer_irq(timer_irq),
		.wake_idle(wake_idle));

	pin_far_side u_pin_far_side (.hclk(hclk), .capture_a_in(cap_a), .capture_b_in(cap_b),
		.ext_count_clock(ext_clk));

	// one single word transfer; called right after a rising edge
	task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] d);
		ahb_req <= '{hsel: 1'b1, htrans: 2'b10, haddr: {26'h0, idx, 2'b00}, hwrite: w,
			hsize: 3'b010};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		ahb_req <= '0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rdx(input logic [3:0] idx);
		xfer(1'b0, idx, 32'h0);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// run needs about 1350 cycles; the limit leaves ample margin
	initial begin
		#80000;
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdx(`IDX_CTL_ONE);
		`CHECK("ctl_one reset", 32'h0, rd)
		`CHECK("okay response", 1'b0, hresp)
		rdx(`IDX_CTL_TWO);
		`CHECK("ctl_two reset", 32'h0, rd)
		rdx(`IDX_CMP_A);
		`CHECK("cmp_a reset", 32'h8000, rd)
		rdx(`IDX_CMP_B);
		`CHECK("cmp_b reset", 32'h8000, rd)
		wr(4'hf, 32'h5a);
		rdx(4'hf);
		`CHECK("unmapped", 32'h0, rd)
		wr(`IDX_CTL_ONE, 32'ha5);
		rdx(`IDX_CTL_ONE);
		`CHECK("ctl_one back", 32'ha5, rd)
		wr(`IDX_CTL_ONE, 32'h0);
		wr(`IDX_CTL_TWO, 32'h5a);
		rdx(`IDX_CTL_TWO);
		`CHECK("ctl_two back", 32'h5a, rd)
		`CHECK("pin enables", 2'b01, {oe_a, oe_b})
		done("registers");
		// counting goes on in idle sleep
		idle_mode <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			wr(`IDX_CTL_TWO, {28'h0, k[1:0], 2'b00});
			rdx(`IDX_COUNT);
			c0 = rd;
			idle(62);
			rdx(`IDX_COUNT);
			`CHECK("ticks", 32'd64 >> (k == 0 ? 2 : k == 1 ? 1 : 3), (rd - c0) & 32'hffff)
		end
		for (int s = 0; s < 2; s++) begin
			wr(`IDX_CTL_TWO, {28'h0, 2'b11, 1'b0, s[0]});
			rdx(`IDX_COUNT);
			c0 = rd;
			u_pin_far_side.drive(1'b1, 1'b1, 1'b1);
			idle(10);
			rdx(`IDX_COUNT);
			c1 = rd;
			u_pin_far_side.drive(1'b1, 1'b1, 1'b0);
			idle(10);
			rdx(`IDX_COUNT);
			`CHECK("rise tick", 32'(s), (c1 - c0) & 32'hffff)
			`CHECK("fall tick", 32'(1 - s), (rd - c1) & 32'hffff)
		end
		done("clocks");
		for (int s = 0; s < 2; s++) begin
			wr(`IDX_CTL_ONE, {24'h0, 1'b1, 5'h0, s[0], 1'b0});
			wr(`IDX_CTL_TWO, {30'h0, s[0], 1'b0});
			for (int v = 0; v < 2; v++) begin
				u_pin_far_side.drive(v[0], v[0], 1'b0);
				idle(8);
				rdx(`IDX_STATUS);
				`CHECK("capture flags", {2{v == s}}, {rd[7], rd[4]})
				`CHECK("irq", v == s, timer_irq)
				`CHECK("idle wake", v == s, wake_idle)
				irq_mask <= 1'b1;
				idle(1);
				`CHECK("masked irq", 1'b0, timer_irq)
				irq_mask <= 1'b0;
				rdx(`IDX_CAP_A);
				rdx(`IDX_CAP_B);
			end
		end
		rdx(`IDX_STATUS);
		`CHECK("flags cleared", 2'b00, {rd[7], rd[4]})
		done("capture");
		wr(`IDX_CTL_TWO, 32'hc4);
		wr(`IDX_CMP_A, 32'h10);
		wr(`IDX_CMP_B, 32'h20);
		wr(`IDX_CTL_ONE, 32'h65);
		rdx(`IDX_STATUS);
		rdx(`IDX_CMP_A);
		rdx(`IDX_CMP_B);
		wr(`IDX_COUNT, 32'h0);
		`CHECK("out a early", 1'b0, out_a)
		`CHECK("irq early", 1'b0, timer_irq)
		idle(120);
		`CHECK("match outs", 2'b11, {out_a, out_b})
		rdx(`IDX_STATUS);
		`CHECK("match flags", 3'b111, {rd[6], rd[5], rd[3]})
		wr(`IDX_CTL_ONE, 32'h45);
		idle(1);
		`CHECK("cmp irq", 1'b1, timer_irq)
		wr(`IDX_CTL_ONE, 32'h25);
		idle(1);
		`CHECK("ovf irq", 1'b1, timer_irq)
		wr(`IDX_CTL_ONE, 32'h18);
		idle(2);
		`CHECK("forced low", 2'b00, {out_a, out_b})
		`CHECK("no irq", 1'b0, timer_irq)
		wr(`IDX_CTL_ONE, 32'h1d);
		idle(2);
		wr(`IDX_CTL_ONE, 32'h00);
		idle(2);
		`CHECK("force kept", 2'b11, {out_a, out_b})
		wr(`IDX_CTL_TWO, 32'h04);
		rdx(`IDX_STATUS);
		rdx(`IDX_CMP_A);
		rdx(`IDX_CMP_B);
		wr(`IDX_COUNT, 32'h0);
		idle(120);
		rdx(`IDX_STATUS);
		`CHECK("pins off", 2'b00, {oe_a, oe_b})
		`CHECK("compare active", 2'b11, {rd[6], rd[3]})
		done("compare");
		wr(`IDX_CMP_A, 32'h4);
		wr(`IDX_CMP_B, 32'h10);
		wr(`IDX_CTL_ONE, 32'h04);
		wr(`IDX_CTL_TWO, 32'h94);
		wr(`IDX_COUNT, 32'h0);
		rdx(`IDX_STATUS);
		rdx(`IDX_CMP_A);
		rdx(`IDX_CMP_B);
		rdx(`IDX_CAP_A);
		idle(100);
		pw = 16'h4 - `CNT_RST + 16'h1;
		per = 16'h10 - `CNT_RST + 16'h1;
		hi = 0;
		repeat (20 * per) begin
			@(posedge hclk);
			hi += out_a;
		end
		`CHECK("pwm high", 20 * pw, hi)
		rdx(`IDX_STATUS);
		`CHECK("pwm flags", 3'b100, {rd[7], rd[6], rd[3]})
		done("pwm");
		wr(`IDX_CMP_A, 32'h8);
		wr(`IDX_CTL_ONE, 32'h06);
		wr(`IDX_CTL_TWO, 32'ha4);
		u_pin_far_side.drive(1'b0, 1'b1, 1'b0);
		idle(6);
		u_pin_far_side.drive(1'b1, 1'b1, 1'b0);
		idle(6);
		`CHECK("pulse on", 1'b1, out_a)
		rdx(`IDX_CAP_A);
		`CHECK("pulse capture", 32'hfffd, rd)
		idle(40);
		`CHECK("pulse off", 1'b0, out_a)
		done("pulse");
		wr(`IDX_CTL_TWO, 32'h06);
		u_pin_far_side.drive(1'b1, 1'b0, 1'b0);
		idle(6);
		rdx(`IDX_STATUS);
		rdx(`IDX_CAP_B);
		stop_mode <= 1'b1;
		idle(2);
		rdx(`IDX_COUNT);
		c0 = rd;
		u_pin_far_side.drive(1'b1, 1'b1, 1'b0);
		idle(40);
		rdx(`IDX_COUNT);
		`CHECK("frozen", c0, rd)
		rdx(`IDX_STATUS);
		`CHECK("armed only", 1'b0, rd[4])
		stop_mode <= 1'b0;
		idle(4);
		rdx(`IDX_STATUS);
		`CHECK("wake flag", 1'b1, rd[4])
		rdx(`IDX_CAP_B);
		`CHECK("wake capture", c0, rd)
		// reset while stopped keeps the counter at its reset value
		stop_mode <= 1'b1;
		hresetn <= 1'b0;
		idle(3);
		hresetn <= 1'b1;
		idle(1);
		rdx(`IDX_COUNT);
		`CHECK("restart", {16'h0, `CNT_RST}, rd)
		rdx(`IDX_CTL_TWO);
		`CHECK("ctl_two again", 32'h0, rd)
		done("stop");
		print_verdict();
	end
endmodule // capture_compare_timer_tb

`default_nettype wire
